// >>> timer_pkg.sv
// Shared constants and types for the millisecond pulse / on-delay / off-delay timer
`default_nettype none
package timer_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ    = 20_000_000;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES    = (CLK_FREQ_HZ / 1_000_000) * TICK_PERIOD_US;
  localparam int unsigned TIME_W         = 32;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] TIMER_RESET    = 32'h0000_0000;
  localparam logic [31:0] STORED_PRESET  = 32'h0000_03e8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    pulse_mode     = 2'b00,
    on_delay_mode  = 2'b01,
    off_delay_mode = 2'b10
  } timer_mode_t;

  typedef struct packed {
    logic        level;
    logic        preset_valid;
    logic [31:0] preset_time;
  } timer_req_t;

  typedef struct packed {
    logic        level;
    logic [31:0] elapsed_time;
  } timer_rsp_t;

endpackage : timer_pkg
`default_nettype wire

// >>> ms_tick_gen.sv
// Millisecond strobe generator from the system clock
`default_nettype none
module ms_tick_gen
  import timer_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic sync_clear,
  output var  logic tick
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Wraps every CYCLES enabled clocks; tick is the wrap cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (clk_en) begin
      if (sync_clear || count == CW'(CYCLES - 1)) begin
        count <= '0;
      end else begin
        count <= count + CW'(1);
      end
    end
  end

  // Gated by the enable so a frozen block never sees a tick
  assign tick = clk_en && !sync_clear && (count == CW'(CYCLES - 1));

endmodule : ms_tick_gen
`default_nettype wire

// >>> preset_select.sv
// Chooses the live preset time or the timer's stored preset
`default_nettype none
module preset_select
  import timer_pkg::*;
#(
  parameter logic [31:0] DEFAULT_PRESET = STORED_PRESET
) (
  input  wire logic        preset_valid,
  input  wire logic [31:0] preset_time,
  output var  logic [31:0] preset_used
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Falls back to the stored preset when no preset is supplied
  always_comb begin
    preset_used = preset_valid ? preset_time : DEFAULT_PRESET;
  end

endmodule : preset_select
`default_nettype wire

// >>> pulse_on_off_delay_timer.sv
// Millisecond timer block with pulse, on-delay and off-delay behaviours
`default_nettype none
module pulse_on_off_delay_timer
  import timer_pkg::*;
#(
  parameter timer_mode_t MODE           = pulse_mode,
  parameter int unsigned TICK_CYC       = TICK_CYCLES,
  parameter logic [31:0] DEFAULT_PRESET = STORED_PRESET
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        sync_reset,
  input  wire timer_req_t  req,
  output var  timer_rsp_t  rsp
);

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  logic [31:0] timer;
  logic        out_level;
  logic        running;
  logic        prev_level;
  logic        tick;
  logic [31:0] preset_used;
  logic        level_rise;
  logic        level_fall;
  logic        at_preset;

  logic [31:0] next_timer;
  logic        next_out_level;
  logic        next_running;

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  ms_tick_gen #(
    .CYCLES     (TICK_CYC)
  ) u_tick (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .sync_clear (sync_reset),
    .tick       (tick)
  );

  preset_select #(
    .DEFAULT_PRESET (DEFAULT_PRESET)
  ) u_preset (
    .preset_valid   (req.preset_valid),
    .preset_time    (req.preset_time),
    .preset_used    (preset_used)
  );

  // ----------------------------------------------------------------
  // Edge detection of the input level
  // ----------------------------------------------------------------
  // Input is synchronous to ref_clk, so one register is enough
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_level <= 1'b0;
    end else if (clk_en) begin
      prev_level <= sync_reset ? 1'b0 : req.level;
    end
  end

  assign level_rise = req.level && !prev_level;
  assign level_fall = !req.level && prev_level;
  // Greater-or-equal catches a preset lowered under a running timer
  assign at_preset  = (timer >= preset_used);

  // ----------------------------------------------------------------
  // Next-state logic per mode
  // ----------------------------------------------------------------
  // Timer steps by one per millisecond tick; the preset is the limit
  always_comb begin
    next_timer     = timer;
    next_out_level = out_level;
    next_running   = running;
    unique case (MODE)
      pulse_mode: begin
        if (running) begin
          if (at_preset) begin
            next_running   = 1'b0;
            next_out_level = 1'b0;
            next_timer     = preset_used;
          end else if (tick) begin
            next_timer = timer + 32'h0000_0001;
          end
        end else if (level_rise && timer == TIMER_RESET) begin
          next_running   = 1'b1;
          next_out_level = 1'b1;
        end else if (!req.level && !out_level) begin
          next_timer = TIMER_RESET;
        end
      end
      on_delay_mode: begin
        if (!req.level) begin
          next_timer     = TIMER_RESET;
          next_out_level = 1'b0;
          next_running   = 1'b0;
        end else if (level_rise) begin
          next_running = 1'b1;
        end else if (running) begin
          if (at_preset) begin
            next_out_level = 1'b1;
            next_running   = 1'b0;
            next_timer     = preset_used;
          end else if (tick) begin
            next_timer = timer + 32'h0000_0001;
          end
        end
      end
      off_delay_mode: begin
        if (req.level) begin
          next_timer     = TIMER_RESET;
          next_out_level = 1'b1;
          next_running   = 1'b0;
        end else if (level_fall) begin
          next_running = out_level;
        end else if (running) begin
          if (at_preset) begin
            next_out_level = 1'b0;
            next_running   = 1'b0;
            next_timer     = preset_used;
          end else if (tick) begin
            next_timer = timer + 32'h0000_0001;
          end
        end
      end
      default: begin
        next_timer     = TIMER_RESET;
        next_out_level = 1'b0;
        next_running   = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Timer register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer <= TIMER_RESET;
    end else if (clk_en) begin
      timer <= sync_reset ? TIMER_RESET : next_timer;
    end
  end

  // ----------------------------------------------------------------
  // Output level and run flag
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_level <= 1'b0;
      running   <= 1'b0;
    end else if (clk_en) begin
      out_level <= sync_reset ? 1'b0 : next_out_level;
      running   <= sync_reset ? 1'b0 : next_running;
    end
  end

  // ----------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------
  // Elapsed time mirrors the timer register, so it clears with it
  always_comb begin
    rsp.level        = out_level;
    rsp.elapsed_time = timer;
  end

endmodule : pulse_on_off_delay_timer
`default_nettype wire

// >>> timer_sva.sv
// Port-level checks for the millisecond timer block
`default_nettype none
module timer_sva
  import timer_pkg::*;
#(
  parameter timer_mode_t MODE           = pulse_mode,
  parameter logic [31:0] DEFAULT_PRESET = STORED_PRESET
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       clk_en,
  input wire logic       sync_reset,
  input wire timer_req_t req,
  input wire timer_rsp_t rsp
);
  logic [31:0] pu;
  logic [31:0] e;
  logic        q;
  logic        go;
  // Preset in force; go marks an enabled edge with no sync clear
  assign pu = req.preset_valid ? req.preset_time : DEFAULT_PRESET;
  assign e  = rsp.elapsed_time;
  assign q  = rsp.level;
  assign go = clk_en && !sync_reset;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  pulse_start_a: assert property (go && MODE == pulse_mode && $rose(req.level) && rsp == '0 |=> q)
    else $error("pulse not started");
  pulse_run_a: assert property (go && MODE == pulse_mode && q && e < pu |=> q)
    else $error("pulse cut short");
  pulse_end_a: assert property (go && MODE == pulse_mode && q && e >= pu |=> !q)
    else $error("pulse overran");
  pulse_clear_a: assert property (go && MODE == pulse_mode && !req.level && !q |=> e == 0)
    else $error("pulse timer kept");
  on_reach_a: assert property (go && MODE == on_delay_mode && req.level && e >= pu |=> q)
    else $error("on-delay late");
  on_fall_a: assert property (go && MODE == on_delay_mode && !req.level |=> rsp == '0)
    else $error("on-delay not cleared");
  off_high_a: assert property (go && MODE == off_delay_mode && req.level |=> q && e == 0)
    else $error("off-delay not held");
  off_reach_a: assert property (go && MODE == off_delay_mode && !req.level && e >= pu |=> !q)
    else $error("off-delay stuck");
  sync_clear_a: assert property (clk_en && sync_reset |=> rsp == '0)
    else $error("sync reset missed");
  cover property (MODE == pulse_mode && $fell(q));
  cover property (MODE == on_delay_mode && $rose(q));
  cover property (MODE == off_delay_mode && $fell(q));
endmodule : timer_sva
bind pulse_on_off_delay_timer timer_sva #(.MODE(MODE), .DEFAULT_PRESET(DEFAULT_PRESET)) u_timer_sva (
  .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .sync_reset(sync_reset), .req(req), .rsp(rsp));
`default_nettype wire

// >>> ctrl_source.sv
// Upstream control logic model driving the timer request
`default_nettype none
module ctrl_source
  import timer_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        lvl,
  input  wire logic        pv,
  input  wire logic [31:0] pt,
  output var  timer_req_t  req
);
  timeunit 1ns;
  timeprecision 1ns;
  // One scan of delay, as control logic updates once per scan
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      req <= '0;
    end else begin
      req <= '{level: lvl, preset_valid: pv, preset_time: pt};
    end
  end
endmodule : ctrl_source
`default_nettype wire

// >>> pulse_on_off_delay_timer_tb.sv
// Self-checking bench for the three timer behaviours
`default_nettype none
`define CHK(n, x, g) begin checks++; if ((g) !== (x)) begin n_fail++; $display("BAD %s exp %0h got %0h", n, x, g); end end
module pulse_on_off_delay_timer_tb import timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] P = 32'h3;
  logic       ref_clk    = 0;
  logic       reset_n    = 0;
  logic       clk_en     = 1;
  logic       sync_reset = 0;
  logic       lvl        = 0;
  logic       pv         = 1;
  timer_req_t req;
  timer_rsp_t rsp [3];
  int         n_fail     = 0;
  int         checks     = 0;
  ctrl_source u_ctrl_source (.ref_clk(ref_clk), .reset_n(reset_n), .lvl(lvl), .pv(pv), .pt(P), .req(req));
  // One block per mode on a shared input; short tick keeps the run brief
  for (genvar g = 0; g < 3; g++) begin : gm
    pulse_on_off_delay_timer #(.MODE(timer_mode_t'(g)), .TICK_CYC(4), .DEFAULT_PRESET(32'h5)) u_pulse_on_off_delay_timer (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .sync_reset(sync_reset), .req(req), .rsp(rsp[g]));
  end
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : settle
  task automatic set_in(input logic l, input logic v);
    @(posedge ref_clk);
    lvl <= l;
    pv  <= v;
  endtask : set_in
  task automatic chk(input int m, input logic l, input logic [31:0] x);
    `CHK("level", l, rsp[m].level)
    `CHK("elapsed", x, rsp[m].elapsed_time)
  endtask : chk
  // Bounded wait for a timer value; a miss counts as a mismatch
  task automatic wait_el(input int m, input logic [31:0] v);
    for (int i = 0; i < 40 && rsp[m].elapsed_time !== v; i++) @(negedge ref_clk);
    `CHK("reach", v, rsp[m].elapsed_time)
  endtask : wait_el
  task automatic long_high;
    set_in(1, 1);
    settle(3);
    chk(0, 1, 0);
    chk(2, 1, 0);
    wait_el(0, P);
    settle(10);
    chk(0, 0, P);
    chk(1, 1, P);
    set_in(0, 1);
    settle(3);
    chk(0, 0, 0);
    chk(1, 0, 0);
    wait_el(2, P);
    settle(2);
    chk(2, 0, P);
  endtask : long_high
  // One-cycle inputs: early fall and early rise
  task automatic short_high;
    set_in(1, 1);
    set_in(0, 1);
    settle(3);
    chk(1, 0, 0);
    wait_el(0, P);
    set_in(1, 1);
    set_in(0, 1);
    wait_el(2, 1);
    set_in(1, 1);
    settle(3);
    chk(2, 1, 0);
    set_in(0, 1);
    settle(30);
    chk(0, 0, 0);
  endtask : short_high
  task automatic stored_preset;
    set_in(1, 0);
    wait_el(1, 4);
    `CHK("on level", 1'b0, rsp[1].level)
    wait_el(1, 5);
    settle(2);
    chk(1, 1, 5);
  endtask : stored_preset
  // Sync clear after the on-delay has finished, then a frozen clock enable must hold a live count
  task automatic sync_freeze;
    @(posedge ref_clk);
    sync_reset <= 1;
    @(posedge ref_clk);
    sync_reset <= 0;
    settle(1);
    chk(1, 0, 0);
    // Clear forgets the old level, so the held input restarts the on-delay count
    wait_el(1, 1);
    @(posedge ref_clk);
    clk_en <= 0;
    settle(13);
    chk(1, 0, 1);
    @(posedge ref_clk);
    clk_en <= 1;
    lvl    <= 0;
  endtask : sync_freeze
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1;
    long_high();
    short_high();
    stored_preset();
    sync_freeze();
    settle(5);
    finish_test();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #250000;
    n_fail++;
    finish_test();
  end
endmodule : pulse_on_off_delay_timer_tb
`default_nettype wire
